/* File: verilog/tpd_timers.sv */
`timescale 1ns/1ps
module tpd_timers (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       sleep_mode,
    input  wire logic                       idle_mode,
    input  wire logic                       debug_mode,
    input  wire logic [tpd_pkg::CTL_W-1:0]  ctl_a,
    input  wire logic [tpd_pkg::CTL_W-1:0]  ctl_lo,
    input  wire logic [tpd_pkg::CTL_W-1:0]  ctl_hi,
    input  wire logic [tpd_pkg::CNT_W-1:0]  period_a,
    input  wire logic [tpd_pkg::CNT_W-1:0]  period_lo,
    input  wire logic [tpd_pkg::CNT_W-1:0]  period_hi,
    input  wire logic [tpd_pkg::NTMR-1:0]   count_wr,
    input  wire logic [tpd_pkg::CNT_W-1:0]  count_wr_data,
    input  wire logic [tpd_pkg::NTMR-1:0]   freeze_wr,
    input  wire logic                       freeze_wr_data,
    input  wire logic [tpd_pkg::NTMR-1:0]   irq_flag_clr,
    input  wire logic                       type_a_irq_enable,
    input  wire logic [tpd_pkg::PRIO_W-1:0] type_a_irq_priority,
    input  wire logic [tpd_pkg::PRIO_W-1:0] cpu_priority,
    input  wire logic [tpd_pkg::NTMR-1:0]   ext_clock_gate_pin,
    output logic      [tpd_pkg::NTMR-1:0]   debug_freeze_bit,
    output logic      [tpd_pkg::NTMR-1:0]   irq_flag,
    output logic      [tpd_pkg::NTMR-1:0]   pin_in_use,
    output logic                            wake_req,
    output logic                            idle_enter,
    output logic                            adc_trigger,
    output logic      [tpd_pkg::CNT_W-1:0]  count_a,
    output logic      [tpd_pkg::CNT_W-1:0]  count_lo,
    output logic      [tpd_pkg::CNT_W-1:0]  count_hi,
    output logic      [2*tpd_pkg::CNT_W-1:0] pair_count
);
    import tpd_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tpd_state_t st_ff;
    tpd_state_t nxt_st;

    logic [CTL_W-1:0] ctl [NTMR];
    logic [CNT_W-1:0] per [NTMR];
    logic [CNT_W-1:0] cnt [NTMR];
    logic             pair;
    logic [NTMR-1:0]  run;
    logic [NTMR-1:0]  gate_mode;
    logic [NTMR-1:0]  rise;
    logic [NTMR-1:0]  fall;
    logic [NTMR-1:0]  tick;
    logic [NTMR-1:0]  match;
    logic [NTMR-1:0]  clr;
    logic [NTMR-1:0]  set_flag;
    logic             match32;
    logic             wake_now;

    assign ctl[TA]  = ctl_a;
    assign ctl[TLO] = ctl_lo;
    assign ctl[THI] = ctl_hi;
    assign per[TA]  = period_a;
    assign per[TLO] = period_lo;
    assign per[THI] = period_hi;
    assign pair     = ctl_lo[CTL_PAIR];

    // ------------------------------------------------------------
    // Counting qualifiers
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NTMR; i++) begin
            rise[i]      = st_ff.pin_s2[i] & ~st_ff.pin_prev[i];
            fall[i]      = ~st_ff.pin_s2[i] & st_ff.pin_prev[i];
            gate_mode[i] = ctl[i][CTL_GATE] & ~ctl[i][CTL_CS];
            run[i]       = ctl[i][CTL_ON];
            // Only the type A timer has an asynchronous path
            if (sleep_mode && !(i == TA && ctl[i][CTL_CS] && !ctl[i][CTL_SYNC])) begin
                run[i] = 1'b0;
            end
            if (idle_mode && ctl[i][CTL_IDLE_STOP]) begin
                run[i] = 1'b0;
            end
            if (debug_mode && st_ff.frz_eff[i]) begin
                run[i] = 1'b0;
            end
            if (ctl[i][CTL_CS]) begin
                tick[i] = run[i] & rise[i];
            end else if (gate_mode[i]) begin
                tick[i] = run[i] & st_ff.pin_s2[i];
            end else begin
                tick[i] = run[i];
            end
        end
        // Upper half follows the lower half when paired
        if (pair) begin
            tick[THI] = tick[TLO] & (cnt[TLO] == CNT_MAX);
        end
    end

    // ------------------------------------------------------------
    // Period compare
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NTMR; i++) begin
            match[i] = tick[i] & (cnt[i] == per[i]);
        end
        match32 = tick[TLO] & ({cnt[THI], cnt[TLO]} == {per[THI], per[TLO]});
        clr     = match;
        if (pair) begin
            clr[TLO] = match32;
            clr[THI] = match32;
        end
    end

    // ------------------------------------------------------------
    // Flag sources
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NTMR; i++) begin
            if (gate_mode[i]) begin
                set_flag[i] = run[i] & fall[i];
            end else begin
                set_flag[i] = match[i] & (per[i] != PER_ZERO);
            end
        end
        if (pair) begin
            // Lower half has no interrupt of its own in pair mode
            set_flag[TLO] = 1'b0;
            if (gate_mode[TLO]) begin
                set_flag[THI] = run[TLO] & fall[TLO];
            end else begin
                set_flag[THI] = match32 &
                                ({per[THI], per[TLO]} != {PER_ZERO, PER_ZERO});
            end
        end
        wake_now = type_a_irq_enable & (type_a_irq_priority > cpu_priority);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.pin_s1   = ext_clock_gate_pin;
        nxt_st.pin_s2   = st_ff.pin_s1;
        nxt_st.pin_prev = st_ff.pin_s2;
        nxt_st.dbg_prev = debug_mode;
        // A set in the clearing cycle survives the clear
        nxt_st.flag     = set_flag | (st_ff.flag & ~irq_flag_clr);
        for (int i = 0; i < NTMR; i++) begin
            if (debug_mode && freeze_wr[i]) begin
                nxt_st.frz_pend[i] = freeze_wr_data;
            end
        end
        // Pending value reaches the freeze only on debug entry
        if (debug_mode && !st_ff.dbg_prev) begin
            nxt_st.frz_eff = st_ff.frz_pend;
        end
        nxt_st.wake    = set_flag[TA] & (sleep_mode | idle_mode) & wake_now;
        nxt_st.idle_go = set_flag[TA] & sleep_mode & ~wake_now;
        // No enable of any kind qualifies the trigger
        nxt_st.trig    = pair ? match32 : match[THI];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff.pin_s1   <= 3'h0;
            st_ff.pin_s2   <= 3'h0;
            st_ff.pin_prev <= 3'h0;
            st_ff.flag     <= FLAG_RST;
            st_ff.frz_pend <= FRZ_RST;
            st_ff.frz_eff  <= FRZ_RST;
            st_ff.dbg_prev <= 1'b0;
            st_ff.wake     <= 1'b0;
            st_ff.idle_go  <= 1'b0;
            st_ff.trig     <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    for (genvar g = 0; g < NTMR; g++) begin : g_cnt
        tpd_count16 u_cnt (
            .clk       (clk),
            .srst      (srst),
            .inc       (tick[g]),
            .clr       (clr[g]),
            .load      (count_wr[g]),
            .load_data (count_wr_data),
            .count     (cnt[g])
        );
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NTMR; i++) begin
            pin_in_use[i] = ctl[i][CTL_CS] | ctl[i][CTL_GATE];
        end
        if (pair) begin
            pin_in_use[THI] = 1'b0;
        end
    end

    assign debug_freeze_bit = debug_mode ? st_ff.frz_pend : 3'h0;
    assign irq_flag    = st_ff.flag;
    assign wake_req    = st_ff.wake;
    assign idle_enter  = st_ff.idle_go;
    assign adc_trigger = st_ff.trig;
    assign count_a     = cnt[TA];
    assign count_lo    = cnt[TLO];
    assign count_hi    = cnt[THI];
    assign pair_count  = {cnt[THI], cnt[TLO]};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Lower timer counting the bus clock with no match or load due
    logic lo_free;
    assign lo_free = ctl_lo[CTL_ON] & ~ctl_lo[CTL_CS] & ~ctl_lo[CTL_GATE] & ~pair
                   & ~sleep_mode & ~count_wr[TLO] & (count_lo != period_lo);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Reset itself is what this check watches, so it is never disabled
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        srst |=> (irq_flag == FLAG_RST && pair_count == {CNT_RST, CNT_RST}
                  && count_a == CNT_RST && !adc_trigger && !wake_req && !idle_enter))
        else $error("Reset left timer state behind");

    AST_SLEEP_HI_STOP: assert property (
        (sleep_mode && !count_wr[THI] && !pair) |=> $stable(count_hi))
        else $error("Upper timer counted during sleep");

    AST_SLEEP_A_RUN: assert property (
        (sleep_mode && ctl_a[CTL_ON] && ctl_a[CTL_CS] && !ctl_a[CTL_SYNC] && rise[TA]
         && !count_wr[TA] && (count_a != period_a) && !idle_mode && !debug_mode)
        |=> (count_a == $past(count_a) + 16'h0001))
        else $error("Async type A missed a pin edge in sleep");

    AST_NO_IDLE_AWAKE: assert property (
        !sleep_mode |=> !idle_enter)
        else $error("Idle request issued outside sleep");

    AST_IDLE_RUN: assert property (
        (lo_free && idle_mode && !ctl_lo[CTL_IDLE_STOP] && !(debug_mode && st_ff.frz_eff[TLO]))
        |=> (count_lo == $past(count_lo) + 16'h0001))
        else $error("Timer stopped in idle with stop bit clear");

    AST_FRZ_OFF_RUN: assert property (
        (lo_free && debug_mode && !st_ff.frz_eff[TLO] && !(idle_mode && ctl_lo[CTL_IDLE_STOP]))
        |=> (count_lo == $past(count_lo) + 16'h0001))
        else $error("Timer stopped in debug without freeze");

    AST_TRIG_ONLY_MATCH: assert property (
        (!pair && !(tick[THI] && (count_hi == period_hi))) |=> !adc_trigger)
        else $error("Conversion trigger without a match");

    AST_PIN_GATE: assert property (
        (ctl_lo[CTL_GATE] && !ctl_lo[CTL_CS]) |-> pin_in_use[TLO])
        else $error("Gate pin not claimed");

    AST_PIN_FREE: assert property (
        (!ctl_a[CTL_CS] && !ctl_a[CTL_GATE]) |-> !pin_in_use[TA])
        else $error("Unused pin claimed by timer");

    AST_FLAG_STICKY_A: assert property (
        (irq_flag[TA] && !irq_flag_clr[TA]) |=> irq_flag[TA])
        else $error("Hardware cleared the type A flag");

    AST_GATE_FALL: assert property (
        (gate_mode[TLO] && !pair && run[TLO] && fall[TLO]) |=> irq_flag[TLO])
        else $error("Gate falling edge set no flag");

    AST_SLEEP_SYNC_STOP: assert property (
        (sleep_mode && !count_wr[TLO] && !pair) |=> (count_lo == $past(count_lo)))
        else $error("Synchronous timer counted during sleep");

    AST_SLEEP_A_QUAL: assert property (
        (sleep_mode && !(ctl_a[CTL_ON] && ctl_a[CTL_CS] && !ctl_a[CTL_SYNC])
         && !count_wr[TA]) |=> $stable(count_a))
        else $error("Type A counted in sleep without async setup");

    AST_WAKE: assert property (
        (set_flag[TA] && sleep_mode && type_a_irq_enable
         && (type_a_irq_priority > cpu_priority)) |=> (wake_req && irq_flag[TA]))
        else $error("Missing wake on enabled higher priority match");

    AST_NO_WAKE: assert property (
        (set_flag[TA] && sleep_mode && (type_a_irq_priority <= cpu_priority))
        |=> (!wake_req && idle_enter))
        else $error("Low priority match woke the device");

    AST_IDLE_STOP: assert property (
        (idle_mode && ctl_lo[CTL_IDLE_STOP] && !count_wr[TLO] && !irq_flag_clr[TLO])
        |=> ($stable(count_lo) && $stable(irq_flag[TLO])))
        else $error("Timer moved in idle with stop bit set");

    AST_FREEZE_HOLD: assert property (
        (debug_mode && st_ff.frz_eff[TLO] && !count_wr[TLO] && !irq_flag_clr[TLO])
        |=> ($stable(count_lo) && !$rose(irq_flag[TLO])))
        else $error("Frozen timer changed state");

    AST_FRZ_READ_ZERO: assert property (
        !debug_mode |-> (debug_freeze_bit == 3'h0))
        else $error("Freeze bit visible outside debug");

    AST_FRZ_DEFER: assert property (
        (debug_mode && $past(debug_mode) && $past(debug_mode, 2)) |-> $stable(st_ff.frz_eff))
        else $error("Freeze value took effect inside debug");

    AST_TRIG16: assert property (
        (!pair && tick[THI] && (count_hi == period_hi)) |=> adc_trigger)
        else $error("Missing 16-bit conversion trigger");

    AST_TRIG32: assert property (
        (pair && tick[TLO] && (pair_count == {period_hi, period_lo})) |=> adc_trigger)
        else $error("Missing 32-bit conversion trigger");

    AST_FLAG_STICKY: assert property (
        (irq_flag[THI] && !irq_flag_clr[THI]) |=> irq_flag[THI])
        else $error("Hardware cleared an interrupt flag");

    AST_PAIR_LOWER_QUIET: assert property (
        (pair && !irq_flag[TLO]) |=> !irq_flag[TLO])
        else $error("Lower half flagged in pair mode");

    AST_ZERO_PERIOD: assert property (
        (period_a == PER_ZERO && !gate_mode[TA] && !irq_flag[TA]) |=> !irq_flag[TA])
        else $error("Zero period raised an interrupt");

    COV_WAKE: cover property (sleep_mode ##1 wake_req);
    COV_TRIG32: cover property (pair ##1 adc_trigger);
    COV_GATE_FALL: cover property (gate_mode[TA] && set_flag[TA]);
    COV_FREEZE: cover property (debug_mode && st_ff.frz_eff[TLO]);
    COV_IDLE: cover property (sleep_mode ##1 idle_enter);

endmodule : tpd_timers

/* File: verilog/tpd_pkg.sv */
// What this block does
// - Sleep stops every clock-synchronised timer
// - Type A counts in sleep: on, external, asynchronous
// - Sleep match sets flag; enabled higher priority wakes
// - Lower or equal priority match enters idle instead
// - Idle-stop bit set halts timer during idle
// - Debug-freeze bit set freezes timer during halt
// - Freeze bit readable only in debug, else zero
// - New freeze value applies after debug re-entry
// - Any reset restores every timer register
// - 16-bit upper match issues conversion trigger
// - 32-bit pair match issues conversion trigger
// - Trigger is never gated by any enable
// - Gate input when gated and internal clock
// - Pin is clock when external source chosen
// - Counts offered as capture and compare time base
// - Pair match reported on upper timer flag
// - Gated mode flags on gate falling edge
// - Zero period never raises an interrupt outside gated mode
package tpd_pkg;

    // ------------------------------------------------------------
    // Timer indices
    // ------------------------------------------------------------
    localparam int NTMR = 3;
    localparam int TA   = 0;
    localparam int TLO  = 1;
    localparam int THI  = 2;

    // ------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------
    localparam int CTL_W        = 16;
    localparam int CTL_ON       = 15;
    localparam int CTL_FRZ      = 14;
    localparam int CTL_IDLE_STOP = 13;
    localparam int CTL_GATE     = 7;
    localparam int CTL_PAIR     = 3;
    localparam int CTL_SYNC     = 2;
    localparam int CTL_CS       = 1;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int CNT_W  = 16;
    localparam int PRIO_W = 3;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] PER_ZERO = 16'h0000;
    localparam logic [NTMR-1:0] FLAG_RST = 3'h0;
    localparam logic [NTMR-1:0] FRZ_RST  = 3'h0;

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } tpd_cnt_t;

    typedef struct packed {
        logic [NTMR-1:0] pin_s1;
        logic [NTMR-1:0] pin_s2;
        logic [NTMR-1:0] pin_prev;
        logic [NTMR-1:0] flag;
        logic [NTMR-1:0] frz_pend;
        logic [NTMR-1:0] frz_eff;
        logic            dbg_prev;
        logic            wake;
        logic            idle_go;
        logic            trig;
    } tpd_state_t;

endpackage : tpd_pkg

/* File: verilog/tpd_count16.sv */
`timescale 1ns/1ps
module tpd_count16 (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      inc,
    input  wire logic                      clr,
    input  wire logic                      load,
    input  wire logic [tpd_pkg::CNT_W-1:0] load_data,
    output logic      [tpd_pkg::CNT_W-1:0] count
);
    import tpd_pkg::*;

    tpd_cnt_t st_ff;
    tpd_cnt_t nxt_st;

    // Software write beats rollover, rollover beats increment
    always_comb begin
        nxt_st = st_ff;
        if (load) begin
            nxt_st.count = load_data;
        end else if (clr) begin
            nxt_st.count = CNT_RST;
        end else if (inc) begin
            nxt_st.count = st_ff.count + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff.count <= CNT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign count = st_ff.count;

endmodule : tpd_count16

/* File: test/tpd_far_model.sv */
`timescale 1ns/1ps
module tpd_far_model (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic [tpd_pkg::NTMR-1:0] pin_direction_reg,
    input  wire logic [tpd_pkg::NTMR-1:0] pin_level,
    input  wire logic                     adc_select,
    input  wire logic                     adc_trigger,
    output logic      [tpd_pkg::NTMR-1:0] ext_clock_gate_pin,
    output logic      [7:0]               adc_starts_ff
);
    import tpd_pkg::*;
    logic [NTMR-1:0] gpio_ff = '0;
    // ----------------------------------------
    // Pin and converter side
    // ----------------------------------------
    // Output direction means plain port data, so a busy pattern shows up
    assign ext_clock_gate_pin = (pin_direction_reg & pin_level)
                              | (~pin_direction_reg & gpio_ff);
    always_ff @(posedge clk) begin
        gpio_ff <= ~gpio_ff;
        if (srst) begin
            adc_starts_ff <= 8'h00;
        end else if (adc_trigger && adc_select) begin
            adc_starts_ff <= adc_starts_ff + 8'h01;
        end
    end
endmodule : tpd_far_model

/* File: test/timer_power_debug_trigger_tb_top.sv */
`timescale 1ns/1ps
module timer_power_debug_trigger_tb_top;
    import tpd_pkg::*;
    logic clk, srst, sleep_mode, idle_mode, debug_mode, freeze_wr_data, adc_select;
    logic [CTL_W-1:0]  ctl_a, ctl_lo, ctl_hi;
    logic [CNT_W-1:0]  period_a, period_lo, period_hi, count_wr_data, count_a, count_lo;
    logic [CNT_W-1:0]  count_hi, v;
    logic [NTMR-1:0]   count_wr, freeze_wr, irq_flag_clr, pins, pin_level, pin_dir;
    logic [NTMR-1:0]   debug_freeze_bit, irq_flag, pin_in_use;
    logic [PRIO_W-1:0] type_a_irq_priority, cpu_priority;
    logic              type_a_irq_enable, wake_req, idle_enter, adc_trigger;
    logic [2*CNT_W-1:0] pair_count;
    logic [7:0]        adc_starts, u0;
    int                fail_count, tests_run, trig_n, wake_n, idle_n, t0;

    tpd_timers DUT (.clk(clk), .srst(srst), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
        .debug_mode(debug_mode), .ctl_a(ctl_a), .ctl_lo(ctl_lo), .ctl_hi(ctl_hi),
        .period_a(period_a), .period_lo(period_lo), .period_hi(period_hi),
        .count_wr(count_wr), .count_wr_data(count_wr_data), .freeze_wr(freeze_wr),
        .freeze_wr_data(freeze_wr_data), .irq_flag_clr(irq_flag_clr),
        .type_a_irq_enable(type_a_irq_enable), .type_a_irq_priority(type_a_irq_priority),
        .cpu_priority(cpu_priority), .ext_clock_gate_pin(pins),
        .debug_freeze_bit(debug_freeze_bit), .irq_flag(irq_flag), .pin_in_use(pin_in_use),
        .wake_req(wake_req), .idle_enter(idle_enter), .adc_trigger(adc_trigger),
        .count_a(count_a), .count_lo(count_lo), .count_hi(count_hi), .pair_count(pair_count));
    tpd_far_model far (.clk(clk), .srst(srst), .pin_direction_reg(pin_dir),
        .pin_level(pin_level), .adc_select(adc_select), .adc_trigger(adc_trigger),
        .ext_clock_gate_pin(pins), .adc_starts_ff(adc_starts));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (adc_trigger === 1'b1) trig_n++;
        if (wake_req === 1'b1) wake_n++;
        if (idle_enter === 1'b1) idle_n++;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wait_trig(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (adc_trigger === 1'b1) return;
        end
        fail_count++;
        $display("[ERR] adc_trigger expected 1 seen none");
        tally_and_finish();
    endtask : wait_trig
    // Three cycles high, four low between pulses and three after the last: two sync flops plus edge detect
    task automatic pulse_pin(input int idx, input int n);
        for (int i = 0; i < n; i++) begin
            cyc(1); pin_level[idx] <= 1'b1;
            cyc(3); pin_level[idx] <= 1'b0;
            cyc(3);
        end
    endtask : pulse_pin
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {sleep_mode, idle_mode, debug_mode, freeze_wr_data, adc_select} = '0;
        {ctl_a, ctl_lo, ctl_hi, period_a, period_lo, period_hi, count_wr_data} = '0;
        {count_wr, freeze_wr, irq_flag_clr, pin_level, pin_dir} = '0;
        {type_a_irq_enable, type_a_irq_priority, cpu_priority} = '0;
        {fail_count, tests_run, trig_n, wake_n, idle_n} = '0;
        srst = 1'b1;
        cyc(10); srst <= 1'b0;
        #1 check("reset counts", {count_a, count_lo}, 32'h0);
        check("reset flags", irq_flag, FLAG_RST);
        cyc(1); period_a <= 16'h0002; ctl_a <= 16'h8000;
        cyc(2); #1 check("count_a run", count_a, 16'h0002);
        cyc(1); #1 check("count_a match", count_a, 16'h0000);
        check("flag_a match", irq_flag[TA], 1'b1);
        cyc(1); ctl_a <= 16'h0000;
        cyc(5); #1 check("flag_a stands", irq_flag[TA], 1'b1);
        cyc(1); irq_flag_clr <= 3'h1;
        cyc(1); irq_flag_clr <= 3'h0;
        #1 check("flag_a cleared", irq_flag[TA], 1'b0);
        cyc(1); ctl_lo <= 16'h8000; period_lo <= 16'hffff; period_a <= 16'h0003;
        ctl_a <= 16'h8002; pin_dir <= 3'h7; type_a_irq_enable <= 1'b1;
        type_a_irq_priority <= 3'h5; cpu_priority <= 3'h2; count_wr <= 3'h1;
        cyc(1); count_wr <= 3'h0;
        cyc(4); sleep_mode <= 1'b1;
        cyc(1); #1 v = count_lo;
        cyc(5); #1 check("sleep stops lo", count_lo, v);
        check("pin as clock", pin_in_use[TA], 1'b1);
        t0 = wake_n;
        pulse_pin(TA, 4);
        cyc(4); #1 check("async count_a", count_a, 16'h0000);
        check("sleep flag", irq_flag[TA], 1'b1);
        check("wake pulses", wake_n - t0, 1);
        cyc(1); irq_flag_clr <= 3'h1; type_a_irq_priority <= 3'h2; t0 = idle_n;
        cyc(1); irq_flag_clr <= 3'h0;
        pulse_pin(TA, 4);
        cyc(4); #1 check("idle pulses", idle_n - t0, 1);
        check("no second wake", wake_n, 1);
        cyc(1); sleep_mode <= 1'b0; idle_mode <= 1'b1; ctl_lo <= 16'ha000;
        cyc(1); #1 v = count_lo;
        cyc(5); #1 check("idle stop holds", count_lo, v);
        cyc(1); ctl_lo <= 16'h8000;
        cyc(1); #1 v = count_lo;
        cyc(5); #1 check("idle run", count_lo, v + 16'h0005);
        cyc(1); idle_mode <= 1'b0; freeze_wr <= 3'h2; freeze_wr_data <= 1'b1;
        cyc(1); freeze_wr <= 3'h0; debug_mode <= 1'b1;
        cyc(1); #1 check("freeze refused", debug_freeze_bit[TLO], 1'b0);
        cyc(1); freeze_wr <= 3'h2;
        cyc(1); freeze_wr <= 3'h0;
        #1 check("freeze reads back", debug_freeze_bit[TLO], 1'b1);
        v = count_lo;
        cyc(5); #1 check("freeze pending", count_lo, v + 16'h0005);
        cyc(1); debug_mode <= 1'b0;
        cyc(1); #1 check("freeze hidden", debug_freeze_bit[TLO], 1'b0);
        cyc(1); debug_mode <= 1'b1;
        cyc(2); #1 v = count_lo;
        cyc(5); #1 check("frozen", count_lo, v);
        cyc(1); debug_mode <= 1'b0;
        cyc(2); #1 v = count_lo;
        cyc(3); #1 check("resumed", count_lo, v + 16'h0003);
        cyc(1); ctl_hi <= 16'h8000; period_hi <= 16'h0003;
        wait_trig(20);
        t0 = trig_n; u0 = adc_starts;
        cyc(16); #1 check("trigger rate", trig_n - t0, 4);
        check("adc unused", adc_starts, u0);
        cyc(1); adc_select <= 1'b1; u0 = adc_starts;
        cyc(16); #1 check("adc used", adc_starts - u0, 8'h04);
        cyc(1); ctl_hi <= 16'h0000; ctl_lo <= 16'h0008; period_lo <= 16'h0002;
        period_hi <= 16'h0001; count_wr <= 3'h2; count_wr_data <= 16'hffff;
        cyc(1); count_wr <= 3'h4; count_wr_data <= 16'h0000;
        cyc(1); count_wr <= 3'h0; irq_flag_clr <= 3'h7;
        cyc(1); irq_flag_clr <= 3'h0; ctl_lo <= 16'h8008;
        #1 check("time base", pair_count, {count_hi, count_lo});
        check("pair load", pair_count, 32'h0000ffff);
        wait_trig(10);
        check("pair wrap", pair_count, 32'h0);
        check("pair upper flag", irq_flag[THI], 1'b1);
        check("pair lower flag", irq_flag[TLO], 1'b0);
        cyc(1); srst <= 1'b1; ctl_lo <= 16'h0000;
        cyc(2); srst <= 1'b0;
        #1 check("rerun reset", pair_count, 32'h0);
        check("rerun flags", irq_flag, FLAG_RST);
        cyc(1); ctl_lo <= 16'h8080; period_lo <= 16'hffff;
        cyc(1); #1 check("pin as gate", pin_in_use[TLO], 1'b1);
        check("gate low", count_lo, 16'h0000);
        cyc(1); pin_level[TLO] <= 1'b1;
        cyc(6); pin_level[TLO] <= 1'b0;
        #1 check("gate counted", count_lo, 16'h0004);
        check("gate no flag yet", irq_flag[TLO], 1'b0);
        cyc(5); #1 check("gate fall flag", irq_flag[TLO], 1'b1);
        check("gate stopped", count_lo, 16'h0006);
        cyc(1); ctl_lo <= 16'h0000; ctl_a <= 16'h8000; period_a <= PER_ZERO;
        cyc(12); #1 check("zero period", irq_flag[TA], 1'b0);
        check("pin free", pin_in_use[TA], 1'b0);
        tally_and_finish();
    end
endmodule : timer_power_debug_trigger_tb_top
